//--- src/pipcs_axil_slave.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// AXI4-Lite slave, one write and one read in flight
module pipcs_axil_slave (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  // Write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Register file side
  pipcs_reg_if.bus_side rif
);
  import pipcs_pkg::*;
  typedef struct packed {
    logic aw_full; logic [7:0] aw_addr;
    logic w_full; logic [31:0] w_data; logic [3:0] w_strb;
    logic bvalid; logic [1:0] bresp;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } pipcs_axil_st_t;
  pipcs_axil_st_t st_reg, st_next;

  // Readies drop while frozen so nothing is taken unseen
  assign awready = aclk_en && !st_reg.aw_full && !st_reg.bvalid;
  assign wready = aclk_en && !st_reg.w_full && !st_reg.bvalid;
  assign arready = aclk_en && !st_reg.rvalid;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign rvalid = st_reg.rvalid;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  assign rif.wr_en = aclk_en && st_reg.aw_full && st_reg.w_full;
  assign rif.wr_addr = st_reg.aw_addr;
  assign rif.wr_data = st_reg.w_data;
  assign rif.wr_strb = st_reg.w_strb;
  assign rif.rd_en = arvalid && arready;
  assign rif.rd_addr = araddr;

  // Next state of both channels
  always_comb begin
    st_next = st_reg;
    if (awvalid && awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = wdata;
      st_next.w_strb = wstrb;
    end
    if (rif.wr_en) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = rif.wr_ok ? PIPCS_RESP_OKAY : PIPCS_RESP_SLVERR;
    end else if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (rif.rd_en) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rif.rd_data;
      st_next.rresp = rif.rd_ok ? PIPCS_RESP_OKAY : PIPCS_RESP_SLVERR;
    end else if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else if (aclk_en) begin
      st_reg <= st_next;
    end
  end
endmodule : pipcs_axil_slave
`default_nettype wire

//--- src/pipcs_cmd_decode.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Command code to operation, per device role
module pipcs_cmd_decode (
  // Command and role
  input wire logic [7:0] cmd,
  input wire logic [7:0] role,
  // Decoded operation, NONE when not legal
  output pipcs_pkg::pipcs_op_t kind
);
  import pipcs_pkg::*;
  logic [3:0] opc;
  assign opc = cmd[PIPCS_OPC_MSB:PIPCS_OPC_LSB];

  // Main role only knows display on and off
  always_comb begin
    kind = PIPCS_OP_NONE;
    if (role == PIPCS_ROLE_MAIN) begin
      if (opc == PIPCS_OPC_START) kind = PIPCS_OP_DISP_ON;
      else if (opc == PIPCS_OPC_STOP) kind = PIPCS_OP_DISP_OFF;
    end else if (role == PIPCS_ROLE_INSET) begin
      case (opc)
        PIPCS_OPC_FILL: kind = PIPCS_OP_FILL_BG;
        PIPCS_OPC_FRAME: kind = PIPCS_OP_FRAME;
        PIPCS_OPC_START: kind = PIPCS_OP_WRITE_START;
        PIPCS_OPC_STOP: kind = PIPCS_OP_WRITE_STOP;
        default: kind = PIPCS_OP_NONE;
      endcase
    end
  end
endmodule : pipcs_cmd_decode
`default_nettype wire

//--- src/pipcs_pkg.sv
// ==========================================
// Shared constants of the command sequencer
package pipcs_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] PIPCS_OFF_ROLE = 8'h00;
  localparam logic [7:0] PIPCS_OFF_LAYOUT = 8'h04;
  localparam logic [7:0] PIPCS_OFF_HPOS = 8'h08;
  localparam logic [7:0] PIPCS_OFF_VPOS = 8'h0C;
  localparam logic [7:0] PIPCS_OFF_LOFF = 8'h10;
  localparam logic [7:0] PIPCS_OFF_POFF = 8'h14;
  localparam logic [7:0] PIPCS_OFF_CMD = 8'h18;
  localparam logic [7:0] PIPCS_OFF_STATUS = 8'h1C;
  localparam logic [7:0] PIPCS_OFF_IRQ_ST = 8'h20;
  localparam logic [7:0] PIPCS_OFF_IRQ_MASK = 8'h24;
  localparam logic [7:0] PIPCS_OFF_LIVE = 8'h28;
  // ==========================================
  // Command fields and codes
  localparam int PIPCS_OPC_MSB = 7;
  localparam int PIPCS_OPC_LSB = 4;
  localparam int PIPCS_COL_MSB = 3;
  localparam int PIPCS_COL_LSB = 2;
  localparam int PIPCS_ROW_MSB = 1;
  localparam int PIPCS_ROW_LSB = 0;
  localparam logic [3:0] PIPCS_OPC_FILL = 4'hC;
  localparam logic [3:0] PIPCS_OPC_FRAME = 4'hA;
  localparam logic [3:0] PIPCS_OPC_START = 4'h8;
  localparam logic [3:0] PIPCS_OPC_STOP = 4'h9;
  localparam logic [7:0] PIPCS_ROLE_INSET = 8'h01;
  localparam logic [7:0] PIPCS_ROLE_MAIN = 8'h05;
  // ==========================================
  // Reset values, status and interrupt bits
  localparam logic [7:0] PIPCS_BYTE_RST = 8'h00;
  localparam logic [11:0] PIPCS_OFFSET_RST = 12'h000;
  localparam logic [31:0] PIPCS_WORD_ZERO = 32'h0000_0000;
  localparam int PIPCS_ST_PENDING = 0;
  localparam int PIPCS_ST_DISPLAY = 1;
  localparam int PIPCS_IRQ_W = 2;
  localparam int PIPCS_IRQ_TAKEN = 0;
  localparam int PIPCS_IRQ_BADCMD = 1;
  localparam logic [1:0] PIPCS_RESP_OKAY = 2'b00;
  localparam logic [1:0] PIPCS_RESP_SLVERR = 2'b10;
  // Operations handed to the field-memory engine
  typedef enum logic [2:0] {
    PIPCS_OP_NONE, PIPCS_OP_FILL_BG, PIPCS_OP_FRAME, PIPCS_OP_WRITE_START,
    PIPCS_OP_WRITE_STOP, PIPCS_OP_DISP_ON, PIPCS_OP_DISP_OFF
  } pipcs_op_t;
endpackage : pipcs_pkg

//--- src/pipcs_reg_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Register access between bus slave and register file
interface pipcs_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus_side (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
  modport reg_side (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : pipcs_reg_if
`default_nettype wire

//--- src/pipcs_top.sv
// Behaviour
// - Offsets default to zero for small grids
// - Host polls pending flag; device clears it
// - Inset role: h'c0 fills background colour
// - Inset role: h'a0 draws the frame
// - Inset role: h'80 starts live writing
// - Main role: h'80 switches inset display on
// - Main role: h'90 switches inset display off
// - Inset role: upper nibble 9 freezes inset
// - Low four bits select the target inset
// - Indices sit in bits 3:2 and 1:0
// - Position rewrites apply without restart
// - Column and row indices from command
// - No range checks or clamping anywhere
`timescale 1ns/100ps
`default_nettype none
module pipcs_top #(
  parameter int POS_W = 12,
  parameter int NUM_INSETS = 16
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Operation to the field-memory engine
  output logic op_valid,
  input wire logic op_ready,
  output pipcs_pkg::pipcs_op_t op_kind,
  output logic [1:0] inset_column_index,
  output logic [1:0] inset_row_index,
  output logic [POS_W-1:0] inset_line_offset,
  output logic [POS_W-1:0] inset_pixel_offset,
  // Live configuration
  output logic [7:0] device_role_select,
  output logic [7:0] pip_layout_select,
  output logic [POS_W-1:0] horizontal_start_position,
  output logic [POS_W-1:0] vertical_start_position,
  output logic [NUM_INSETS-1:0] live_write_mask,
  output logic display_on,
  output logic command_pending_flag,
  // Interrupt
  output logic irq
);
  import pipcs_pkg::*;

  // ==========================================
  // State
  typedef enum logic {PIPCS_S_IDLE, PIPCS_S_ISSUE} pipcs_fsm_t;
  typedef struct packed {
    logic [7:0] role;
    logic [7:0] layout;
    logic [POS_W-1:0] hpos;
    logic [POS_W-1:0] vpos;
    logic [POS_W-1:0] loff;
    logic [POS_W-1:0] poff;
    logic [7:0] cmd;
    logic pending;
    pipcs_fsm_t fsm;
    pipcs_op_t op_kind;
    logic [7:0] op_code;
    logic [NUM_INSETS-1:0] live;
    logic disp;
    logic [PIPCS_IRQ_W-1:0] irq_st;
    logic [PIPCS_IRQ_W-1:0] irq_mask;
  } pipcs_top_st_t;
  pipcs_top_st_t st_reg, st_next;

  pipcs_reg_if rif ();
  pipcs_op_t dec_kind;
  logic [31:0] wr_word;
  logic [PIPCS_IRQ_W-1:0] ev;
  logic [3:0] op_idx;
  logic cmd_wr;
  logic taken;

  // ==========================================
  // Helpers
  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction : wmerge

  // Decode of the register map, shared by read and write
  function automatic logic mapped(input logic [7:0] addr);
    case (addr)
      PIPCS_OFF_ROLE, PIPCS_OFF_LAYOUT, PIPCS_OFF_HPOS, PIPCS_OFF_VPOS,
      PIPCS_OFF_LOFF, PIPCS_OFF_POFF, PIPCS_OFF_CMD, PIPCS_OFF_STATUS,
      PIPCS_OFF_IRQ_ST, PIPCS_OFF_IRQ_MASK, PIPCS_OFF_LIVE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // ==========================================
  // Bus slave and command decoder
  pipcs_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclk_en(aclk_en),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .rif(rif)
  );

  pipcs_cmd_decode u_decode (
    .cmd(st_reg.cmd),
    .role(st_reg.role),
    .kind(dec_kind)
  );

  // ==========================================
  // Register read path; unmapped reads answer SLVERR
  assign rif.wr_ok = mapped(rif.wr_addr);
  assign rif.rd_ok = mapped(rif.rd_addr);
  always_comb begin
    rif.rd_data = PIPCS_WORD_ZERO;
    case (rif.rd_addr)
      PIPCS_OFF_ROLE: rif.rd_data[7:0] = st_reg.role;
      PIPCS_OFF_LAYOUT: rif.rd_data[7:0] = st_reg.layout;
      PIPCS_OFF_HPOS: rif.rd_data[POS_W-1:0] = st_reg.hpos;
      PIPCS_OFF_VPOS: rif.rd_data[POS_W-1:0] = st_reg.vpos;
      PIPCS_OFF_LOFF: rif.rd_data[POS_W-1:0] = st_reg.loff;
      PIPCS_OFF_POFF: rif.rd_data[POS_W-1:0] = st_reg.poff;
      PIPCS_OFF_CMD: rif.rd_data[7:0] = st_reg.cmd;
      PIPCS_OFF_STATUS: begin
        rif.rd_data[PIPCS_ST_PENDING] = st_reg.pending;
        rif.rd_data[PIPCS_ST_DISPLAY] = st_reg.disp;
      end
      PIPCS_OFF_IRQ_ST: rif.rd_data[PIPCS_IRQ_W-1:0] = st_reg.irq_st;
      PIPCS_OFF_IRQ_MASK: rif.rd_data[PIPCS_IRQ_W-1:0] = st_reg.irq_mask;
      PIPCS_OFF_LIVE: rif.rd_data[NUM_INSETS-1:0] = st_reg.live;
      default: rif.rd_data = PIPCS_WORD_ZERO;
    endcase
  end

  // ==========================================
  // Next state: sequencer, then register writes
  assign cmd_wr = rif.wr_en && rif.wr_addr == PIPCS_OFF_CMD && rif.wr_strb[0];
  assign taken = st_reg.fsm == PIPCS_S_ISSUE && op_ready;
  assign op_idx = st_reg.op_code[PIPCS_COL_MSB:PIPCS_ROW_LSB];
  always_comb begin
    st_next = st_reg;
    ev = '0;
    wr_word = PIPCS_WORD_ZERO;
    case (st_reg.fsm)
      PIPCS_S_IDLE: begin
        if (st_reg.pending) begin
          if (dec_kind == PIPCS_OP_NONE) begin
            // Unknown code for this role: drop it, flag it
            st_next.pending = 1'b0;
            ev[PIPCS_IRQ_BADCMD] = 1'b1;
          end else begin
            st_next.fsm = PIPCS_S_ISSUE;
            st_next.op_kind = dec_kind;
            st_next.op_code = st_reg.cmd;
          end
        end
      end
      PIPCS_S_ISSUE: begin
        if (op_ready) begin
          st_next.fsm = PIPCS_S_IDLE;
          st_next.pending = 1'b0;
          ev[PIPCS_IRQ_TAKEN] = 1'b1;
          case (st_reg.op_kind)
            PIPCS_OP_WRITE_START: st_next.live[op_idx] = 1'b1;
            PIPCS_OP_WRITE_STOP: st_next.live[op_idx] = 1'b0;
            PIPCS_OP_DISP_ON: st_next.disp = 1'b1;
            PIPCS_OP_DISP_OFF: st_next.disp = 1'b0;
            default: st_next.disp = st_reg.disp;
          endcase
        end
      end
      default: st_next.fsm = PIPCS_S_IDLE;
    endcase
    // Writes come last so a fresh command beats the clear
    if (rif.wr_en) begin
      case (rif.wr_addr)
        PIPCS_OFF_ROLE: begin
          wr_word = wmerge({24'h00_0000, st_reg.role}, rif.wr_data, rif.wr_strb);
          st_next.role = wr_word[7:0];
        end
        PIPCS_OFF_LAYOUT: begin
          wr_word = wmerge({24'h00_0000, st_reg.layout}, rif.wr_data, rif.wr_strb);
          st_next.layout = wr_word[7:0];
        end
        // Stored as written, nothing clamped
        PIPCS_OFF_HPOS: begin
          wr_word = wmerge(32'(st_reg.hpos), rif.wr_data, rif.wr_strb);
          st_next.hpos = wr_word[POS_W-1:0];
        end
        PIPCS_OFF_VPOS: begin
          wr_word = wmerge(32'(st_reg.vpos), rif.wr_data, rif.wr_strb);
          st_next.vpos = wr_word[POS_W-1:0];
        end
        PIPCS_OFF_LOFF: begin
          wr_word = wmerge(32'(st_reg.loff), rif.wr_data, rif.wr_strb);
          st_next.loff = wr_word[POS_W-1:0];
        end
        PIPCS_OFF_POFF: begin
          wr_word = wmerge(32'(st_reg.poff), rif.wr_data, rif.wr_strb);
          st_next.poff = wr_word[POS_W-1:0];
        end
        PIPCS_OFF_CMD: begin
          if (rif.wr_strb[0]) begin
            st_next.cmd = rif.wr_data[7:0];
            st_next.pending = 1'b1;
          end
        end
        PIPCS_OFF_IRQ_ST: begin
          wr_word = wmerge(PIPCS_WORD_ZERO, rif.wr_data, rif.wr_strb);
        end
        PIPCS_OFF_IRQ_MASK: begin
          wr_word = wmerge(32'(st_reg.irq_mask), rif.wr_data, rif.wr_strb);
          st_next.irq_mask = wr_word[PIPCS_IRQ_W-1:0];
        end
        default: wr_word = PIPCS_WORD_ZERO;
      endcase
    end
    // Write-one-to-clear; a same-cycle event wins
    if (rif.wr_en && rif.wr_addr == PIPCS_OFF_IRQ_ST) begin
      st_next.irq_st = (st_reg.irq_st & ~wr_word[PIPCS_IRQ_W-1:0]) | ev;
    end else begin
      st_next.irq_st = st_reg.irq_st | ev;
    end
  end

  // ==========================================
  // State register; offsets come up zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.role <= PIPCS_BYTE_RST;
      st_reg.layout <= PIPCS_BYTE_RST;
      st_reg.loff <= POS_W'(PIPCS_OFFSET_RST);
      st_reg.poff <= POS_W'(PIPCS_OFFSET_RST);
      st_reg.fsm <= PIPCS_S_IDLE;
      st_reg.op_kind <= PIPCS_OP_NONE;
    end else if (aclk_en) begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // Outputs, all from flops except the masked irq
  assign op_valid = st_reg.fsm == PIPCS_S_ISSUE;
  assign op_kind = st_reg.op_kind;
  assign inset_column_index = st_reg.op_code[PIPCS_COL_MSB:PIPCS_COL_LSB];
  assign inset_row_index = st_reg.op_code[PIPCS_ROW_MSB:PIPCS_ROW_LSB];
  assign inset_line_offset = st_reg.loff;
  assign inset_pixel_offset = st_reg.poff;
  assign device_role_select = st_reg.role;
  assign pip_layout_select = st_reg.layout;
  assign horizontal_start_position = st_reg.hpos;
  assign vertical_start_position = st_reg.vpos;
  assign live_write_mask = st_reg.live;
  assign display_on = st_reg.disp;
  assign command_pending_flag = st_reg.pending;
  assign irq = |(st_reg.irq_st & st_reg.irq_mask);

  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_OFFS_ZERO: assert property ($past(!aresetn) |-> inset_line_offset == '0 && inset_pixel_offset == '0)
    else $error("offsets not zero after reset");
  AST_PEND_SET: assert property (aclk_en && cmd_wr |=> command_pending_flag)
    else $error("pending not set by command write");
  AST_PEND_CLR: assert property (aclk_en && taken && !cmd_wr |=> !command_pending_flag && !op_valid)
    else $error("pending not cleared when taken");
  AST_FILL: assert property (op_valid && st_reg.op_code[PIPCS_OPC_MSB:PIPCS_OPC_LSB] == PIPCS_OPC_FILL
    |-> op_kind == PIPCS_OP_FILL_BG)
    else $error("fill code not issued as fill");
  AST_FRAME: assert property (op_valid && st_reg.op_code[PIPCS_OPC_MSB:PIPCS_OPC_LSB] == PIPCS_OPC_FRAME
    |-> op_kind == PIPCS_OP_FRAME)
    else $error("frame code not issued as frame");
  AST_START: assert property (aclk_en && taken && op_kind == PIPCS_OP_WRITE_START
    |=> live_write_mask[$past(op_idx)])
    else $error("live writing not started");
  AST_STOP: assert property (aclk_en && taken && op_kind == PIPCS_OP_WRITE_STOP
    |=> !live_write_mask[$past(op_idx)])
    else $error("live writing not stopped");
  AST_DISP_ON: assert property (aclk_en && taken && op_kind == PIPCS_OP_DISP_ON |=> display_on)
    else $error("display not switched on");
  AST_DISP_OFF: assert property (aclk_en && taken && op_kind == PIPCS_OP_DISP_OFF |=> !display_on)
    else $error("display not switched off");
  AST_INDEX: assert property (aclk_en && st_reg.fsm == PIPCS_S_IDLE && st_reg.pending
    && dec_kind != PIPCS_OP_NONE
    |=> op_valid && {inset_column_index, inset_row_index} == $past(st_reg.cmd[PIPCS_COL_MSB:PIPCS_ROW_LSB]))
    else $error("inset index not from command");
  AST_HPOS: assert property (aclk_en && rif.wr_en && rif.wr_addr == PIPCS_OFF_HPOS && &rif.wr_strb
    |=> horizontal_start_position == $past(rif.wr_data[POS_W-1:0]))
    else $error("new position not applied");
  AST_PEND_HOLD: assert property (aclk_en && command_pending_flag && !taken
    && !(st_reg.fsm == PIPCS_S_IDLE && dec_kind == PIPCS_OP_NONE) |=> command_pending_flag)
    else $error("pending dropped before command taken");
endmodule : pipcs_top
`default_nettype wire

//--- tb/pipcs_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Field-memory engine model, takes each operation after a set stall
module pipcs_engine_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Operation handshake
  input wire logic op_valid,
  input wire logic [1:0] stall,
  output logic op_ready
);
  logic [1:0] wait_reg;
  // Ready only after the stall, so slow takes hold the pending flag up
  assign op_ready = op_valid && (wait_reg >= stall);
  // Cycles the current operation has waited
  always_ff @(posedge aclk) begin
    if (!aresetn || !op_valid || op_ready) wait_reg <= 2'h0;
    else wait_reg <= wait_reg + 2'h1;
  end
endmodule : pipcs_engine_model
`default_nettype wire

//--- tb/test_pip_command_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench acting as host over the register bus
module test_pip_command_sequencer;
  import pipcs_pkg::*;
  logic aclk, aresetn, aclk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, op_valid, op_ready, display_on, command_pending_flag, irq;
  logic [7:0] awaddr, araddr, device_role_select, pip_layout_select;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb, got_idx;
  logic [1:0] bresp, rresp, inset_column_index, inset_row_index, stall, wr_resp, rd_resp;
  logic [11:0] inset_line_offset, inset_pixel_offset, horizontal_start_position, vertical_start_position;
  logic [15:0] live_write_mask;
  pipcs_op_t op_kind, got_kind;
  int mismatches = 0;
  int total_checks = 0;
  int n_ops = 0;
  int n;
  pipcs_top DUT (.aclk, .aresetn, .aclk_en, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .op_valid,
    .op_ready, .op_kind, .inset_column_index, .inset_row_index, .inset_line_offset, .inset_pixel_offset,
    .device_role_select, .pip_layout_select, .horizontal_start_position, .vertical_start_position,
    .live_write_mask, .display_on, .command_pending_flag, .irq);
  pipcs_engine_model engine (.aclk, .aresetn, .op_valid, .stall, .op_ready);
  // ==========
  // Clock, timeout and operation capture
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_sim();
  end
  // Latch each operation at its handshake edge
  always @(posedge aclk) begin
    if (op_valid && op_ready) begin
      got_kind <= op_kind;
      got_idx <= {inset_column_index, inset_row_index};
      n_ops <= n_ops + 1;
    end
  end
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    wr_resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd_val = rdata;
    rd_resp = rresp;
  endtask : rd
  // Write a command, poll pending low, compare the issued operation
  task automatic cmd(input logic [7:0] c, input pipcs_op_t k);
    int i;
    wr(PIPCS_OFF_CMD, {24'h0, c});
    if (stall == 2'h3) chk(command_pending_flag, 1'b1);
    i = 0;
    do begin
      rd(PIPCS_OFF_STATUS);
      i++;
    end while (rd_val[0] !== 1'b0 && i < 20);
    chk(rd_val[0], 1'b0);
    if (k != PIPCS_OP_NONE) begin
      chk(got_kind, k);
      chk(got_idx, c[3:0]);
    end
  endtask : cmd
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // ==========
  // Test sequence
  initial begin
    aresetn = 1'b0;
    aclk_en = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    stall = 2'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PIPCS_OFF_LOFF);
    chk(rd_val, 32'h0000_0000);
    chk(rd_resp, PIPCS_RESP_OKAY);
    rd(PIPCS_OFF_POFF);
    chk(rd_val, 32'h0000_0000);
    $display("test reset done");
    wr(PIPCS_OFF_ROLE, 32'h0000_0001);
    wr(PIPCS_OFF_LAYOUT, 32'h0000_000F);
    chk(wr_resp, PIPCS_RESP_OKAY);
    chk(device_role_select, 8'h01);
    chk(pip_layout_select, 8'h0F);
    cmd(8'hC0, PIPCS_OP_FILL_BG);
    cmd(8'hA0, PIPCS_OP_FRAME);
    stall <= 2'h3;
    cmd(8'h80, PIPCS_OP_WRITE_START);
    cmd(8'hC4, PIPCS_OP_FILL_BG);
    cmd(8'h84, PIPCS_OP_WRITE_START);
    chk(live_write_mask, 16'h0011);
    stall <= 2'h0;
    cmd(8'h91, PIPCS_OP_WRITE_STOP);
    cmd(8'h90, PIPCS_OP_WRITE_STOP);
    rd(PIPCS_OFF_LIVE);
    chk(rd_val, 32'h0000_0010);
    wr(PIPCS_OFF_HPOS, 32'h0000_0101);
    chk(horizontal_start_position, 12'h101);
    chk(live_write_mask, 16'h0010);
    wr(PIPCS_OFF_VPOS, 32'h0000_0202);
    chk(vertical_start_position, 12'h202);
    wr(PIPCS_OFF_LOFF, 32'h0000_02B8);
    cmd(8'hC1, PIPCS_OP_FILL_BG);
    chk(inset_line_offset, 12'h2B8);
    wr(PIPCS_OFF_POFF, 32'h0000_0FFF);
    chk(inset_pixel_offset, 12'hFFF);
    rd(PIPCS_OFF_POFF);
    chk(rd_val, 32'h0000_0FFF);
    $display("test inset role done");
    wr(PIPCS_OFF_ROLE, 32'h0000_0005);
    cmd(8'h80, PIPCS_OP_DISP_ON);
    chk(display_on, 1'b1);
    rd(PIPCS_OFF_STATUS);
    chk(rd_val, 32'h0000_0002);
    cmd(8'h90, PIPCS_OP_DISP_OFF);
    chk(display_on, 1'b0);
    $display("test main role done");
    n = n_ops;
    cmd(8'hC0, PIPCS_OP_NONE);
    chk(n_ops, n);
    chk(op_valid, 1'b0);
    rd(PIPCS_OFF_IRQ_ST);
    chk(rd_val, 32'h0000_0003);
    chk(irq, 1'b0);
    wr(PIPCS_OFF_IRQ_MASK, 32'h0000_0002);
    @(posedge aclk);
    chk(irq, 1'b1);
    wr(PIPCS_OFF_IRQ_ST, 32'h0000_0003);
    @(posedge aclk);
    chk(irq, 1'b0);
    rd(PIPCS_OFF_IRQ_ST);
    chk(rd_val, 32'h0000_0000);
    wr(8'h3C, 32'h0000_0001);
    chk(wr_resp, PIPCS_RESP_SLVERR);
    rd(8'h3C);
    chk(rd_val, 32'h0000_0000);
    chk(rd_resp, PIPCS_RESP_SLVERR);
    // Frozen block must refuse every bus request
    aclk_en <= 1'b0;
    @(posedge aclk);
    chk(awready, 1'b0);
    chk(arready, 1'b0);
    chk(wready, 1'b0);
    aclk_en <= 1'b1;
    $display("test irq and errors done");
    end_sim();
  end
endmodule : test_pip_command_sequencer
`default_nettype wire
